// >>> rtl/ptd_drv_sel.sv
// Registered selection of the driver resistance code and timing handed to the antenna driver output.
`timescale 1ns/10ps
`default_nettype none
module ptd_drv_sel
  import ptd_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Codes and phase.
  input  wire logic        mod_phase,
  input  wire logic [3:0]  mod_code,
  input  wire logic [3:0]  unmod_code,
  input  wire ptd_timing_t timing_in,
  // Driver setting.
  output ptd_drv_t         drv
);

  logic [3:0] code_d;

  // Pick the code for the current load modulation phase.
  assign code_d = mod_phase ? mod_code : unmod_code;

  // Register the setting so the driver sees glitch-free data.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drv <= '{hiz: 1'b0, res_code: 4'h0, timing: PTD_TIM_FAST};
    end else begin
      drv.res_code <= code_d;
      drv.hiz      <= (code_d == PTD_RES_HIZ);
      drv.timing   <= timing_in;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/ptd_pkg.sv
// Package with register map, field layout, reset values and timing codes of the driver setup registers.
package ptd_pkg;

  // Register addresses; the resistance and timing registers share one address, told apart by the space select.
  localparam logic [7:0] PTD_ADDR_SHARED = 8'h29;
  localparam logic [7:0] PTD_ADDR_STATUS = 8'h2b;

  // Field positions in the resistance register.
  localparam int PTD_MOD_RES_MSB   = 7;
  localparam int PTD_MOD_RES_LSB   = 4;
  localparam int PTD_UNMOD_RES_MSB = 3;
  localparam int PTD_UNMOD_RES_LSB = 0;

  // Field positions in the timing register.
  localparam int PTD_RATIO_MSB   = 7;
  localparam int PTD_RATIO_LSB   = 4;
  localparam int PTD_MAN_SEL_BIT = 3;
  localparam int PTD_MAN_TIM_MSB = 2;
  localparam int PTD_MAN_TIM_LSB = 0;

  // Field positions in the acquisition status register.
  localparam int PTD_STAT_START_BIT = 0;
  localparam int PTD_STAT_BUSY_BIT  = 6;
  localparam int PTD_STAT_DONE_BIT  = 7;

  // Reset values: modulated code 0111, unmodulated 0000, ratio 0111, manual select 1, manual code 100.
  localparam logic [7:0] PTD_RES_RST = 8'h70;
  localparam logic [7:0] PTD_TIM_RST = 8'h7c;

  // Resistance code that floats the driver output.
  localparam logic [3:0] PTD_RES_HIZ = 4'hf;

  // Acquisition budget: five transient steps within ten RF periods.
  localparam int PTD_ACQ_STEPS       = 5;
  localparam int PTD_ACQ_MAX_RF      = 10;
  localparam int PTD_ACQ_RF_PER_STEP = PTD_ACQ_MAX_RF / PTD_ACQ_STEPS;

  // Driver transient settings, slowest first.
  typedef enum logic [2:0] {
    PTD_TIM_SLOW     = 3'h0,
    PTD_TIM_MED_SLOW = 3'h1,
    PTD_TIM_NOMINAL  = 3'h2,
    PTD_TIM_MED_FAST = 3'h3,
    PTD_TIM_FAST     = 3'h4
  } ptd_timing_t;

  // Setting carried to the antenna driver output.
  typedef struct packed {
    logic        hiz;
    logic [3:0]  res_code;
    ptd_timing_t timing;
  } ptd_drv_t;

  // Manual timing decode: any code with the top bit set means fast.
  function automatic ptd_timing_t ptd_man_timing(input logic [2:0] code);
    ptd_timing_t t;
    t = code[2] ? PTD_TIM_FAST : ptd_timing_t'(code);
    return t;
  endfunction

endpackage

// >>> rtl/ptd_regs.sv
// Passive target resistance and driver transient timing registers with automatic transient acquisition.
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module ptd_regs
  import ptd_pkg::*;
#(
  // Number of transient settings the acquisition may visit.
  parameter int ACQ_STEPS = PTD_ACQ_STEPS
)
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Register port.
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_space_b,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // Measurement side.
  input  wire logic       rf_tick_pin,
  input  wire logic [3:0] ratio_meas,
  input  wire logic       acq_start,
  // Load modulation phase from the modulator.
  input  wire logic       load_mod_phase,
  // Antenna driver setting and acquisition state.
  output ptd_drv_t        antenna_driver_output,
  output logic            acq_busy,
  output logic            acq_done
);

  // Acquisition states.
  typedef enum logic [1:0] {
    PTD_ACQ_IDLE    = 2'b00,
    PTD_ACQ_SETTLE  = 2'b01,
    PTD_ACQ_MEASURE = 2'b10,
    PTD_ACQ_DONE    = 2'b11
  } ptd_acq_t;

  logic [7:0]  res_q;
  logic [7:0]  tim_q;
  ptd_acq_t    state_q;
  logic [2:0]  step_q;
  logic        rf_tick;
  logic        wr_res;
  logic        wr_tim;
  logic        wr_stat;
  logic        start;
  logic        reached;
  logic        last_step;
  ptd_timing_t timing_sel;
  logic [3:0]  target_ratio;
  logic        step_up;
  logic        sel_res;
  logic        sel_tim;
  logic        sel_stat;

  // The stepped setting indexes the timing codes, so more steps than codes cannot be served.
  if (ACQ_STEPS < 1 || ACQ_STEPS > PTD_ACQ_STEPS) begin
    $error("ACQ_STEPS must lie between 1 and the number of transient settings.");
  end

  // True when the address and the space select name the given register.
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic       space_b,
                                   input logic [7:0] want_addr,
                                   input logic       want_space_b);
    return (addr == want_addr) && (space_b == want_space_b);
  endfunction

  // Address decode; the space select separates the two registers sharing 29h.
  assign sel_res  = reg_hit(reg_addr, reg_space_b, PTD_ADDR_SHARED, 1'b0);
  assign sel_tim  = reg_hit(reg_addr, reg_space_b, PTD_ADDR_SHARED, 1'b1);
  assign sel_stat = reg_hit(reg_addr, reg_space_b, PTD_ADDR_STATUS, 1'b1);
  assign wr_res   = reg_wr & sel_res;
  assign wr_tim   = reg_wr & sel_tim;
  assign wr_stat  = reg_wr & sel_stat;

  // Resistance register, both codes.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res_q <= PTD_RES_RST;
    end else if (wr_res) begin
      res_q <= reg_wdata;
    end
  end

  // Timing register: target ratio, manual select and manual code.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tim_q <= PTD_TIM_RST;
    end else if (wr_tim) begin
      tim_q <= reg_wdata;
    end
  end

  // Read data stand in the cycle after the read strobe; unmapped addresses read zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (sel_res) begin
        reg_rdata <= res_q;
      end else if (sel_tim) begin
        reg_rdata <= tim_q;
      end else if (sel_stat) begin
        reg_rdata <= {acq_done, acq_busy, 3'h0, step_q};
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // The RF period tick arrives from the analog front end and is synchronised first.
  ptd_sync_edge u_rf_sync (
    .clk        (clk),
    .rst        (rst),
    .async_in   (rf_tick_pin),
    .rise_pulse (rf_tick)
  );

  // Acquisition restarts on the start input, a status write with the start bit set, or a timing register write.
  assign start        = acq_start | (wr_stat & reg_wdata[PTD_STAT_START_BIT]) | wr_tim;
  assign target_ratio = tim_q[PTD_RATIO_MSB:PTD_RATIO_LSB];
  assign reached      = (ratio_meas >= target_ratio);
  assign last_step    = (step_q == 3'(ACQ_STEPS - 1));
  assign step_up      = (state_q == PTD_ACQ_MEASURE) && rf_tick && !reached && !last_step;

  // Each step waits one RF period for the driver to settle and measures in the next.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= PTD_ACQ_IDLE;
    end else if (start) begin
      state_q <= PTD_ACQ_SETTLE;
    end else begin
      unique case (state_q)
        PTD_ACQ_IDLE: begin
          state_q <= PTD_ACQ_IDLE;
        end
        PTD_ACQ_SETTLE: begin
          if (rf_tick) begin
            state_q <= PTD_ACQ_MEASURE;
          end
        end
        PTD_ACQ_MEASURE: begin
          if (rf_tick) begin
            if (reached || last_step) begin
              state_q <= PTD_ACQ_DONE;
            end else begin
              state_q <= PTD_ACQ_SETTLE;
            end
          end
        end
        PTD_ACQ_DONE: begin
          state_q <= PTD_ACQ_DONE;
        end
      endcase
    end
  end

  // Transient step: slowest on every start, one faster after each measurement below target before the last step.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_q <= 3'h0;
    end else if (start) begin
      step_q <= 3'h0;
    end else if (step_up) begin
      step_q <= step_q + 3'h1;
    end
  end

  assign acq_busy = (state_q == PTD_ACQ_SETTLE) || (state_q == PTD_ACQ_MEASURE);
  assign acq_done = (state_q == PTD_ACQ_DONE);

  // Manual code wins when the select bit is set; otherwise the stepped setting applies.
  assign timing_sel = tim_q[PTD_MAN_SEL_BIT] ? ptd_man_timing(tim_q[PTD_MAN_TIM_MSB:PTD_MAN_TIM_LSB])
                                            : ptd_timing_t'(step_q);

  // Driver code and timing selection, registered.
  ptd_drv_sel u_drv_sel (
    .clk        (clk),
    .rst        (rst),
    .mod_phase  (load_mod_phase),
    .mod_code   (res_q[PTD_MOD_RES_MSB:PTD_MOD_RES_LSB]),
    .unmod_code (res_q[PTD_UNMOD_RES_MSB:PTD_UNMOD_RES_LSB]),
    .timing_in  (timing_sel),
    .drv        (antenna_driver_output)
  );

  // Helper count of RF ticks seen during one acquisition.
  logic [4:0] acq_ticks_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acq_ticks_q <= 5'h00;
    end else if (start) begin
      acq_ticks_q <= 5'h00;
    end else if (acq_busy && rf_tick) begin
      acq_ticks_q <= acq_ticks_q + 5'h01;
    end
  end

  // Helper count of RF ticks spent on the current transient step.
  logic [1:0] step_ticks_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_ticks_q <= 2'h0;
    end else if (start || step_up) begin
      step_ticks_q <= 2'h0;
    end else if (acq_busy && rf_tick) begin
      step_ticks_q <= step_ticks_q + 2'h1;
    end
  end

  // Checks sample on the block clock and rest while reset is held.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  mod_code_out_a : assert property (
    load_mod_phase && !wr_res |=> antenna_driver_output.res_code == $past(res_q[7:4]))
    else $error("Modulated code not applied.");

  unmod_code_out_a : assert property (
    !load_mod_phase && !wr_res |=> antenna_driver_output.res_code == $past(res_q[3:0]))
    else $error("Unmodulated code not applied.");

  hiz_flag_a : assert property (
    antenna_driver_output.hiz == (antenna_driver_output.res_code == PTD_RES_HIZ))
    else $error("High impedance flag mismatch.");

  acq_slowest_a : assert property (
    start |=> state_q == PTD_ACQ_SETTLE && step_q == 3'h0)
    else $error("Acquisition did not start at slowest.");

  acq_stop_target_a : assert property (
    state_q == PTD_ACQ_MEASURE && rf_tick && reached && !start |=> acq_done && $stable(step_q))
    else $error("Acquisition did not stop at target.");

  acq_step_bound_a : assert property (
    step_q <= 3'(ACQ_STEPS - 1) && acq_ticks_q <= 5'(ACQ_STEPS * PTD_ACQ_RF_PER_STEP))
    else $error("Acquisition exceeded five steps or ten periods.");

  man_select_a : assert property (
    $past(tim_q[3]) |-> antenna_driver_output.timing == ptd_man_timing($past(tim_q[2:0])))
    else $error("Manual timing not applied.");

  auto_select_a : assert property (
    !$past(tim_q[3]) |-> antenna_driver_output.timing == ptd_timing_t'($past(step_q)))
    else $error("Acquired timing not applied.");

  man_fast_a : assert property (
    $past(tim_q[3] && tim_q[2]) |-> antenna_driver_output.timing == PTD_TIM_FAST)
    else $error("Manual code 1xx not fast.");

  read_shared_a : assert property (
    reg_rd && reg_addr == PTD_ADDR_SHARED ##1 1'b1 |-> reg_rdata == ($past(reg_space_b) ? $past(tim_q) : $past(res_q)))
    else $error("Shared address read returned wrong register.");

  // Register storage and read port checks.
  res_write_a : assert property (
    wr_res |=> res_q == $past(reg_wdata))
    else $error("Resistance register write lost.");

  res_keep_a : assert property (
    !wr_res |=> $stable(res_q))
    else $error("Resistance register changed without its write.");

  tim_write_a : assert property (
    wr_tim |=> tim_q == $past(reg_wdata))
    else $error("Timing register write lost.");

  tim_keep_a : assert property (
    !wr_tim |=> $stable(tim_q))
    else $error("Timing register changed without its write.");

  read_idle_a : assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("Read data not cleared outside a read.");

  read_unmapped_a : assert property (
    reg_rd && !sel_res && !sel_tim && !sel_stat |=> reg_rdata == 8'h00)
    else $error("Unmapped read returned data.");

  // Acquisition sequencing checks.
  tim_restart_a : assert property (
    wr_tim |=> acq_busy && step_q == 3'h0)
    else $error("Timing write did not restart at the slowest transient.");

  stat_restart_a : assert property (
    wr_stat && reg_wdata[PTD_STAT_START_BIT] |=> acq_busy && step_q == 3'h0)
    else $error("Status start did not restart at the slowest transient.");

  acq_measure_a : assert property (
    state_q == PTD_ACQ_SETTLE && rf_tick && !start |=> state_q == PTD_ACQ_MEASURE && $stable(step_q))
    else $error("Settled step did not move to its measurement.");

  acq_step_up_a : assert property (
    state_q == PTD_ACQ_MEASURE && rf_tick && !reached && !last_step && !start |=>
      state_q == PTD_ACQ_SETTLE && step_q == $past(step_q) + 3'h1)
    else $error("Acquisition did not move to a faster transient.");

  acq_last_stop_a : assert property (
    state_q == PTD_ACQ_MEASURE && rf_tick && last_step && !start |=> acq_done && $stable(step_q))
    else $error("Acquisition ran past its last step.");

  acq_wait_a : assert property (
    acq_busy && !rf_tick && !start |=> $stable(state_q) && $stable(step_q))
    else $error("Acquisition moved without an RF period.");

  acq_done_hold_a : assert property (
    acq_done && !start |=> acq_done && $stable(step_q))
    else $error("Acquired setting not held.");

  step_ticks_a : assert property (
    step_ticks_q <= 2'(PTD_ACQ_RF_PER_STEP))
    else $error("One transient step used more than its RF periods.");

  tick_pulse_a : assert property (
    rf_tick |=> !rf_tick)
    else $error("RF period tick longer than one cycle.");

  // Driver output checks.
  timing_legal_a : assert property (
    antenna_driver_output.timing <= PTD_TIM_FAST)
    else $error("Driver timing code out of range.");

endmodule
`default_nettype wire

// >>> rtl/ptd_sync_edge.sv
// Two-stage synchroniser with a rising-edge pulse for the RF period tick pin.
`timescale 1ns/10ps
`default_nettype none
module ptd_sync_edge
  import ptd_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Asynchronous level in, one-cycle pulse out.
  input  wire logic async_in,
  output logic      rise_pulse
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // The first stage is read only by the second; the edge detector looks at the later stages.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // One pulse per rising edge of the synchronised level.
  assign rise_pulse = sync_q & ~last_q;

endmodule
`default_nettype wire

// >>> verification/tb_ptd_regs.sv
// Self-checking testbench for the resistance and transient timing registers.
`timescale 1ns/10ps
`default_nettype none
module tb_ptd_regs;
  import ptd_pkg::*;

  logic       clk, rst, reg_space_b, reg_wr, reg_rd;
  logic       rf_tick_pin, acq_start, load_mod_phase, acq_busy, acq_done;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] ratio_meas;
  ptd_drv_t   drv;
  int         failures, n_checks;

  // Device under test.
  ptd_regs u_dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_space_b(reg_space_b),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rf_tick_pin(rf_tick_pin), .ratio_meas(ratio_meas), .acq_start(acq_start),
    .load_mod_phase(load_mod_phase), .antenna_driver_output(drv),
    .acq_busy(acq_busy), .acq_done(acq_done)
  );

  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Compares one byte-wide result.
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle register write.
  task automatic wr(input logic sp, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_space_b <= sp;
    reg_addr    <= a;
    reg_wdata   <= d;
    reg_wr      <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle register read; data are looked at in the cycle after the strobe.
  task automatic rd(input logic sp, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_space_b <= sp;
    reg_addr    <= a;
    reg_rd      <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    cmp8("read data", exp, reg_rdata);
  endtask

  // One RF period on the tick pin, with the ratio the measurement will see.
  task automatic tick(input logic [3:0] r);
    @(posedge clk);
    ratio_meas  <= r;
    rf_tick_pin <= 1'b1;
    repeat (4) @(posedge clk);
    rf_tick_pin <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Reset values, unmapped places and read-back in both spaces.
  task automatic t_reset_map();
    rd(1'b0, PTD_ADDR_SHARED, 8'h70);
    rd(1'b1, PTD_ADDR_SHARED, 8'h7c);
    cmp8("reset timing", 8'h04, {5'h00, drv.timing});
    wr(1'b0, 8'h2c, 8'hff);
    rd(1'b0, 8'h2c, 8'h00);
    wr(1'b0, PTD_ADDR_SHARED, 8'h5a);
    rd(1'b1, PTD_ADDR_SHARED, 8'h7c);
    rd(1'b0, PTD_ADDR_SHARED, 8'h5a);
  endtask

  // Resistance code follows the load modulation phase; code 15 floats the driver.
  task automatic t_res();
    logic [7:0] regv [2];
    regv = '{8'ha5, 8'hf3};
    for (int i = 0; i < 2; i++) begin
      wr(1'b0, PTD_ADDR_SHARED, regv[i]);
      load_mod_phase <= 1'b1;
      repeat (3) @(posedge clk);
      cmp8("mod drive", {3'h0, regv[i][7:4] == 4'hf, regv[i][7:4]}, {3'h0, drv.hiz, drv.res_code});
      load_mod_phase <= 1'b0;
      repeat (3) @(posedge clk);
      cmp8("unmod drive", {4'h0, regv[i][3:0]}, {3'h0, drv.hiz, drv.res_code});
    end
  endtask

  // Every manual timing code with manual selection on.
  task automatic t_manual();
    logic [2:0] exp;
    for (int c = 0; c < 8; c++) begin
      exp = c[2] ? 3'h4 : c[2:0];
      wr(1'b1, PTD_ADDR_SHARED, {4'h7, 1'b1, c[2:0]});
      repeat (3) @(posedge clk);
      cmp8("manual timing", {5'h00, exp}, {5'h00, drv.timing});
      rd(1'b1, PTD_ADDR_SHARED, {4'h7, 1'b1, c[2:0]});
    end
  endtask

  // Automatic acquisition; the ratio seen rises by one for each step.
  task automatic t_auto(input logic [3:0] target, input int nticks, input logic [2:0] step, input logic restart);
    int i;
    wr(1'b1, PTD_ADDR_SHARED, {target, 4'h0});
    if (restart) begin
      // Reach step 1, then restart through the status start bit and through the start input.
      tick(4'h0);
      tick(4'h0);
      wr(1'b1, PTD_ADDR_STATUS, 8'h01);
      rd(1'b1, PTD_ADDR_STATUS, 8'h40);
      tick(4'h0);
      tick(4'h0);
      @(posedge clk);
      acq_start <= 1'b1;
      @(posedge clk);
      acq_start <= 1'b0;
      rd(1'b1, PTD_ADDR_STATUS, 8'h40);
    end
    for (i = 1; i <= nticks; i++) begin
      tick(4'((i - 1) / 2));
      if (i == nticks - 2) cmp8("busy mid run", 8'h01, {6'h00, acq_done, acq_busy});
    end
    for (i = 0; i < 20 && acq_done !== 1'b1; i++) @(posedge clk);
    if (acq_done !== 1'b1) begin
      cmp8("acquisition done", 8'h01, {7'h00, acq_done});
      report_and_stop();
    end
    rd(1'b1, PTD_ADDR_STATUS, {5'h10, step});
    cmp8("acquired timing", {5'h00, step}, {5'h00, drv.timing});
  endtask

  // Main sequence.
  initial begin
    failures = 0;
    n_checks = 0;
    rst = 1'b1;
    {reg_space_b, reg_wr, reg_rd, rf_tick_pin, acq_start, load_mod_phase} = '0;
    reg_addr   = 8'h00;
    reg_wdata  = 8'h00;
    ratio_meas = 4'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset_map();
    t_res();
    t_manual();
    t_auto(4'h3, 8, 3'h3, 1'b0);
    t_auto(4'hf, 10, 3'h4, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
